// ===== hw/iceps_pkg.sv
// Purpose: constants and types of the escape and poll sequencer
// Assumes: 100 MHz clk, APB register access
// Notes: state numbers follow the sixteen-state counter
// Behaviour
// - escape state zero clears the selection flip-flop first
// - line transitions in escape states zero and one restart the quiet count
// - escape sends the link-escape code, only bit five set, in state seven
// - two parity bits from check flop a in states ten and eleven
// - transmit gate set before a character, cleared after its parity bits
// - end of escape sets the selection flip-flop
// - load-poll flop toggles only in escape state thirteen while polling
// - guard set at power-on or in state fifteen after a held instruction, cleared in state twelve with load-poll
// - with guard clear, channel-busy set means an instruction is handled, not polled
// - first poll after start-up is the load-request poll
// - load poll sends device zero with bits five and six set
// - load poll forces both parity bits to one
// - service poll clocks states three to eleven, counter device, bit six set
// - poll counter steps before a service poll unless attention flag or freeze flag set
// - no clock after a poll: no retry, return to escape state zero
// - acknowledgement is clock, mid-bit data, clock; only the first is used
// - missing transition repeats exchange; polled device waits its next turn
// - mid-bit transition sets data flop, checked after the acknowledgement
// - verified acknowledgement resets the retry latch
// - verified poll answer sets load flag or attention flag by load-poll
// - after an answer the counter freezes until channel-busy is set
// - acknowledgement to a selection sets neither flag
// - line timeout runs while retry is set, restarted by normal exchanges
package iceps_pkg;
	localparam int CLK_MHZ = 100;
	localparam int BIT_NS = 1000;
	localparam int BIT_CYC = (BIT_NS * CLK_MHZ) / 1000;
	localparam int ACK_NS = 4000;
	localparam int ACK_CYC = (ACK_NS * CLK_MHZ) / 1000;
	localparam int TIMEOUT_MS = 20;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
	localparam logic [7:0] TICK_LAST = 8'(BIT_CYC - 1);
	localparam logic [7:0] TICK_MID = 8'(BIT_CYC / 2);
	localparam logic [8:0] ACK_LAST = 9'(ACK_CYC - 1);
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [6:0] ESC_CHAR = 7'h10;
	localparam logic [6:0] LOAD_POLL_CHAR = 7'h30;
	localparam logic [6:0] SVC_POLL_CHAR = 7'h20;
	localparam logic [3:0] ST_QUIET = 4'h1;
	localparam logic [3:0] ST_GATE_ON = 4'h2;
	localparam logic [3:0] ST_B1 = 4'h3;
	localparam logic [3:0] ST_B7 = 4'h9;
	localparam logic [3:0] ST_PAR_A = 4'ha;
	localparam logic [3:0] ST_PAR_B = 4'hb;
	localparam logic [3:0] ST_GATE_OFF = 4'hc;
	localparam logic [3:0] ST_ACK = 4'hd;
	localparam logic [3:0] ST_GUARD = 4'hf;
	typedef enum logic [1:0] {
		ICEPS_ESC = 2'b00,
		ICEPS_SEL = 2'b01,
		ICEPS_HOLD = 2'b10
	} iceps_mode_t;
	typedef struct packed {
		logic [3:0] sel_dev;
		logic [3:0] max_dev;
		logic [3:0] min_dev;
		logic [2:0] pad;
		logic poll_en;
	} iceps_ctrl_t;
	localparam iceps_ctrl_t CTRL_RST = '{4'h0, 4'hf, 4'h1, 3'h0, 1'b1};
	typedef struct packed {
		iceps_mode_t mode;
		logic [3:0] st;
		logic [3:0] poll_cnt;
		logic gate;
		logic freeze;
		logic select;
		logic retry;
		logic load_poll;
		logic guard;
		logic attn;
		logic prog;
	} iceps_stat_t;
	typedef struct packed {
		iceps_ctrl_t ctrl;
		iceps_mode_t mode;
		logic [3:0] st;
		logic [7:0] tick;
		logic [1:0] aph;
		logic [8:0] ackt;
		logic [20:0] tmo;
		logic [6:0] chr;
		logic [3:0] poll_cnt;
		logic [2:0] cs;
		logic [2:0] ds;
		logic lvl_c;
		logic lvl_d;
		logic ck_a;
		logic ck_b;
		logic force_par;
		logic gate;
		logic clk_o;
		logic dat_o;
		logic select;
		logic load_poll;
		logic guard;
		logic after_op;
		logic retry;
		logic data_ff;
		logic freeze;
		logic prog;
		logic attn;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} iceps_state_t;
endpackage : iceps_pkg

// ===== hw/iceps_sequencer.sv
// Purpose: escape and polling sequencer of a serial channel controller
// Assumes: processor signals on clk, line pins asynchronous
// Notes: selection and data transfer live elsewhere
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module iceps_sequencer
#(
	parameter int TIMEOUT_CYC = iceps_pkg::TIMEOUT_CYC
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic line_clk_i,
	output logic line_clk_o,
	output logic line_clk_oe,
	input wire logic line_dat_i,
	output logic line_dat_o,
	output logic line_dat_oe,
	input wire logic channel_busy,
	input wire logic attention_flag_clear,
	input wire logic program_load_clear,
	output logic program_load_flag,
	output logic attention_flag,
	output logic line_transmit_gate,
	output logic select_active
);
	iceps_pkg::iceps_state_t r;
	iceps_pkg::iceps_state_t n;
	iceps_pkg::iceps_stat_t stat;
	logic clk_ev;
	logic dat_ev;
	logic first;
	logic mid;
	logic tick_end;
	logic polling;
	logic tx_state;
	logic bit_val;
	logic go_esc;
	logic ack_ok;
	logic ack_bad;
	logic ack_none;
	logic [3:0] nxt_dev;

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign line_clk_o = r.clk_o;
	assign line_dat_o = r.dat_o;
	assign line_clk_oe = r.gate;
	assign line_dat_oe = r.gate;
	assign program_load_flag = r.prog;
	assign attention_flag = r.attn;
	assign line_transmit_gate = r.gate;
	assign select_active = r.select;

	always_comb
	begin
		n = r;
		go_esc = 1'b0;
		ack_ok = 1'b0;
		ack_bad = 1'b0;
		ack_none = 1'b0;
		bit_val = 1'b0;
		nxt_dev = r.poll_cnt;
		polling = r.ctrl.poll_en;
		first = (r.tick == 8'h00);
		mid = (r.tick == iceps_pkg::TICK_MID);
		tick_end = (r.tick == iceps_pkg::TICK_LAST);
		tx_state = (r.mode != iceps_pkg::ICEPS_HOLD) && (r.st >= iceps_pkg::ST_B1)
			&& (r.st <= iceps_pkg::ST_PAR_B);

		// a level counts once second and third stages agree
		n.cs = {r.cs[1:0], line_clk_i};
		n.ds = {r.ds[1:0], line_dat_i};
		clk_ev = (r.cs[1] == r.cs[2]) && (r.cs[2] != r.lvl_c);
		dat_ev = (r.ds[1] == r.ds[2]) && (r.ds[2] != r.lvl_d);
		n.lvl_c = clk_ev ? r.cs[2] : r.lvl_c;
		n.lvl_d = dat_ev ? r.ds[2] : r.lvl_d;

		// bit timing; in select mode the acknowledgement state waits on line events instead
		if (r.mode != iceps_pkg::ICEPS_HOLD && r.st != iceps_pkg::ST_ACK)
		begin
			n.tick = tick_end ? 8'h00 : r.tick + 8'h01;
			if (tick_end)
			begin
				n.st = r.st + 4'h1;
			end
		end

		// serial transmitter: clock at bit start, data transition mid-bit for a one
		if (r.st <= iceps_pkg::ST_B7)
		begin
			bit_val = r.chr[3'(r.st - iceps_pkg::ST_B1)];
		end
		else
		begin
			bit_val = r.force_par | r.ck_a;
		end
		if (tx_state && first)
		begin
			n.clk_o = ~r.clk_o;
		end
		if (tx_state && mid && bit_val)
		begin
			n.dat_o = ~r.dat_o;
			if (r.st <= iceps_pkg::ST_B7)
			begin
				n.ck_a = ~r.ck_a;
				if (r.ck_a)
				begin
					n.ck_b = ~r.ck_b;
				end
			end
		end
		// second parity bit carries what flop b held in state ten
		if (tx_state && tick_end && r.st == iceps_pkg::ST_PAR_A)
		begin
			n.ck_a = r.ck_b;
		end

		unique case (r.mode)
			iceps_pkg::ICEPS_ESC:
			begin
				if (r.st == 4'h0 && first)
				begin
					n.select = 1'b0;
				end
				if (r.st <= iceps_pkg::ST_QUIET && (clk_ev || dat_ev))
				begin
					n.st = 4'h0;
					n.tick = 8'h00;
				end
				if (r.st == iceps_pkg::ST_GATE_ON && first)
				begin
					n.gate = 1'b1;
					n.chr = iceps_pkg::ESC_CHAR;
					n.force_par = 1'b0;
					n.ck_a = 1'b0;
					n.ck_b = 1'b0;
				end
				if (r.st == iceps_pkg::ST_GATE_OFF && first)
				begin
					n.gate = 1'b0;
					if (r.load_poll)
					begin
						n.guard = 1'b0;
					end
				end
				if (r.st == iceps_pkg::ST_ACK && first)
				begin
					n.select = 1'b1;
					if (polling)
					begin
						n.load_poll = ~r.load_poll;
						n.retry = 1'b0;
					end
				end
				// the acknowledgement state only waits in select mode
				if (r.st == iceps_pkg::ST_ACK)
				begin
					n.tick = tick_end ? 8'h00 : r.tick + 8'h01;
					if (tick_end)
					begin
						n.st = r.st + 4'h1;
					end
				end
				if (r.st == iceps_pkg::ST_GUARD && first && r.after_op)
				begin
					n.guard = 1'b1;
					n.after_op = 1'b0;
				end
				if (r.st == iceps_pkg::ST_GUARD && tick_end)
				begin
					n.mode = iceps_pkg::ICEPS_SEL;
					n.st = 4'h0;
				end
			end
			iceps_pkg::ICEPS_SEL:
			begin
				if (r.st == 4'h0 && first && !r.guard && channel_busy)
				begin
					n.mode = iceps_pkg::ICEPS_HOLD;
					n.freeze = 1'b0;
				end
				if (r.st == iceps_pkg::ST_GATE_ON && first)
				begin
					n.gate = 1'b1;
					n.ck_a = 1'b0;
					n.ck_b = 1'b0;
					n.force_par = 1'b0;
					if (polling && r.load_poll)
					begin
						n.chr = iceps_pkg::LOAD_POLL_CHAR;
						n.force_par = 1'b1;
					end
					else if (polling)
					begin
						if (!r.attn && !r.freeze)
						begin
							// wrap returns to min_dev after max_dev; a count below min_dev steps up by one
							nxt_dev = (r.poll_cnt >= r.ctrl.max_dev)
								? r.ctrl.min_dev : r.poll_cnt + 4'h1;
						end
						n.poll_cnt = nxt_dev;
						n.chr = iceps_pkg::SVC_POLL_CHAR | {3'h0, nxt_dev};
					end
					else
					begin
						n.chr = iceps_pkg::SVC_POLL_CHAR | {3'h0, r.ctrl.sel_dev};
					end
				end
				if (r.st == iceps_pkg::ST_GATE_OFF && first)
				begin
					n.gate = 1'b0;
				end
				if (r.st == iceps_pkg::ST_ACK)
				begin
					n.tick = 8'h00;
					n.ackt = r.ackt + 9'h001;
					unique case (r.aph)
						2'h0:
						begin
							if (clk_ev)
							begin
								n.aph = 2'h1;
								n.ackt = 9'h000;
							end
							else if (r.ackt == iceps_pkg::ACK_LAST)
							begin
								ack_none = 1'b1;
							end
						end
						2'h1:
						begin
							if (dat_ev)
							begin
								n.data_ff = 1'b1;
								n.aph = 2'h2;
								n.ackt = 9'h000;
							end
							else if (clk_ev || r.ackt == iceps_pkg::ACK_LAST)
							begin
								ack_bad = 1'b1;
							end
						end
						2'h2:
						begin
							if (clk_ev)
							begin
								ack_ok = r.data_ff;
								ack_bad = ~r.data_ff;
							end
							else if (r.ackt == iceps_pkg::ACK_LAST)
							begin
								ack_bad = 1'b1;
							end
						end
						default:
						begin
							ack_bad = 1'b1;
						end
					endcase
				end
				if (ack_none)
				begin
					n.retry = ~polling;
					go_esc = 1'b1;
				end
				// a polled device that failed simply waits for its next turn
				if (ack_bad)
				begin
					n.retry = ~polling | r.retry;
					go_esc = 1'b1;
				end
				if (ack_ok)
				begin
					n.retry = 1'b0;
					n.tmo = 21'h000000;
					if (polling)
					begin
						n.freeze = 1'b1;
						if (r.load_poll)
						begin
							n.prog = 1'b1;
						end
						else
						begin
							n.attn = 1'b1;
						end
					end
					go_esc = 1'b1;
				end
			end
			iceps_pkg::ICEPS_HOLD:
			begin
				if (!channel_busy)
				begin
					n.after_op = 1'b1;
					go_esc = 1'b1;
				end
			end
			default:
			begin
				go_esc = 1'b1;
			end
		endcase

		// the second acknowledgement lands in the quiet check and is ignored
		if (r.retry)
		begin
			n.tmo = r.tmo + 21'h000001;
			if (r.tmo == 21'(TIMEOUT_CYC - 1))
			begin
				n.retry = 1'b0;
				n.tmo = 21'h000000;
				n.gate = 1'b0;
				go_esc = 1'b1;
			end
		end
		else
		begin
			n.tmo = 21'h000000;
		end

		if (go_esc)
		begin
			n.mode = iceps_pkg::ICEPS_ESC;
			n.st = 4'h0;
			n.tick = 8'h00;
			n.aph = 2'h0;
			n.ackt = 9'h000;
			n.data_ff = 1'b0;
		end

		// clears lose against a set in the same cycle
		if (attention_flag_clear && !(ack_ok && polling && !r.load_poll))
		begin
			n.attn = 1'b0;
		end
		if (program_load_clear && !(ack_ok && polling && r.load_poll))
		begin
			n.prog = 1'b0;
		end

		stat = '{r.mode, r.st, r.poll_cnt, r.gate, r.freeze, r.select, r.retry,
			r.load_poll, r.guard, r.attn, r.prog};

		// apb slave: one wait state, answer in the second access cycle
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && penable && !r.pready)
		begin
			n.pready = 1'b1;
			n.prdata = 32'h00000000;
			if (paddr == iceps_pkg::CTRL_OFS)
			begin
				if (pwrite)
				begin
					n.ctrl = iceps_pkg::iceps_ctrl_t'(pwdata[15:0]);
					n.ctrl.pad = 3'h0;
				end
				else
				begin
					n.prdata = {16'h0000, r.ctrl};
				end
			end
			else if (paddr == iceps_pkg::STAT_OFS && !pwrite)
			begin
				n.prdata = {14'h0000, stat};
			end
			else
			begin
				n.pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r <= '0;
			r.guard <= 1'b1;
			r.ctrl <= iceps_pkg::CTRL_RST;
		end
		else
		begin
			r <= n;
		end
	end
endmodule : iceps_sequencer

// ===== tb/iceps_seq_assertions.sv
// Purpose: concurrent checks on the sequencer ports
// Assumes: single clock domain, synchronous reset
// Notes: bound into every sequencer instance
`timescale 1ns/10ps
module iceps_seq_assertions (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic line_clk_oe,
	input wire logic line_dat_oe,
	input wire logic line_transmit_gate,
	input wire logic select_active,
	input wire logic attention_flag,
	input wire logic attention_flag_clear,
	input wire logic program_load_flag
);
	logic [10:0] gate_cnt;
	logic bad;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence apb_access;
		psel && penable && !pready;
	endsequence
	assign bad = (paddr != iceps_pkg::CTRL_OFS && paddr != iceps_pkg::STAT_OFS)
		|| (pwrite && paddr == iceps_pkg::STAT_OFS);
	// counts sampled gate cycles, so a frame length can be judged at the falling edge
	always_ff @(posedge clk)
		if (srst || !line_transmit_gate)
			gate_cnt <= '0;
		else
			gate_cnt <= gate_cnt + 11'h001;
	apb_answer_a: assert property (apb_access |=> pready)
		else $error("bus answer late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	addr_error_a: assert property (apb_access |=> pslverr == $past(bad))
		else $error("bus error flag wrong");
	gate_enable_a: assert property (line_clk_oe == line_transmit_gate && line_dat_oe == line_transmit_gate)
		else $error("drive enables differ from gate");
	frame_length_a: assert property ($fell(line_transmit_gate) && !$past(srst) |-> gate_cnt == 11'h3e8)
		else $error("frame length wrong");
	attn_clear_a: assert property ($fell(attention_flag) |-> $past(attention_flag_clear) || $past(srst))
		else $error("attention flag dropped");
	flag_after_ack_a: assert property ($rose(attention_flag) || $rose(program_load_flag)
		|-> !line_transmit_gate && !$past(line_transmit_gate, 50))
		else $error("flag set while sending");
	select_set_a: assert property ($rose(select_active) |-> !line_transmit_gate)
		else $error("selection set during frame");
endmodule : iceps_seq_assertions

bind iceps_sequencer iceps_seq_assertions iceps_seq_assertions_i (.clk, .srst, .psel, .penable, .pwrite, .paddr,
	.pready, .pslverr, .line_clk_oe, .line_dat_oe, .line_transmit_gate, .select_active, .attention_flag,
	.attention_flag_clear, .program_load_flag);

// ===== tb/iceps_line_unit.sv
// Purpose: behavioural line unit on the two-wire line
// Assumes: controller enables mark its frames
// Notes: answers load or service polls, can omit the data transition
`timescale 1ns/10ps
module iceps_line_unit #(
	// a shorter delay lets the first clock land before the controller starts listening
	parameter int DLY = 12
)
(
	input wire logic line_clk_o,
	input wire logic line_clk_oe,
	input wire logic line_dat_o,
	input wire logic line_dat_oe,
	input wire logic load_req,
	input wire logic svc_req,
	input wire logic drop_data,
	input wire logic [3:0] dev,
	output logic line_clk,
	output logic line_dat,
	output logic rx_done,
	output logic [6:0] rx_char,
	output logic [1:0] rx_par
);
	logic lk = 1'b0;
	logic m_oe = 1'b0;
	logic mc;
	logic md;
	logic [9:1] bits;
	int n = 0;
	always #62.5 lk = ~lk;
	initial
	begin
		line_clk = 1'b0;
		line_dat = 1'b0;
		rx_done = 1'b0;
	end
	// bus keepers hold a released wire, so a release is never a transition
	always @*
		if (line_clk_oe === 1'b1)
			line_clk = line_clk_o;
		else if (m_oe)
			line_clk = mc;
	always @*
		if (line_dat_oe === 1'b1)
			line_dat = line_dat_o;
		else if (m_oe)
			line_dat = md;
	always @(line_clk)
		if (line_clk_oe === 1'b1)
			n = n + 1;
	always @(line_dat)
		if (line_dat_oe === 1'b1 && n > 0 && n < 10)
			bits[n] = 1'b1;
	// late clear drops the level change that may come with the gate itself
	always @(posedge line_clk_oe)
	begin
		#1;
		n = 0;
		bits = '0;
	end
	always @(negedge line_clk_oe)
		if (n >= 9)
		begin
			rx_char = bits[7:1];
			rx_par = bits[9:8];
			rx_done = 1'b1;
			#1 rx_done = 1'b0;
			if ((rx_char == iceps_pkg::LOAD_POLL_CHAR && load_req) || (rx_char == {3'b010, dev} && svc_req))
				ack();
		end
	task automatic ack();
		logic keep_data;
		// latched at the frame end, the bench may change the input during the answer
		keep_data = !drop_data;
		repeat (DLY) @(posedge lk);
		mc = line_clk;
		md = line_dat;
		m_oe = 1'b1;
		repeat (2)
		begin
			mc = ~mc;
			repeat (4) @(posedge lk);
			if (keep_data)
				md = ~md;
			repeat (4) @(posedge lk);
			mc = ~mc;
			repeat (4) @(posedge lk);
		end
		m_oe = 1'b0;
	endtask : ack
endmodule : iceps_line_unit

// ===== tb/iceps_tb.sv
// Purpose: self-checking bench of the escape and poll sequencer
// Assumes: line unit model on the wire pair, devices 1 to 3
// Notes: frames and bus answers are checked in arrival order
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] ESC = {1'b0, iceps_pkg::ESC_CHAR};
	localparam logic [7:0] LDP = {1'b0, iceps_pkg::LOAD_POLL_CHAR};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, line_clk, line_dat, line_clk_o, line_clk_oe, line_dat_o, line_dat_oe;
	logic channel_busy = 1'b0;
	logic attention_flag_clear = 1'b0;
	logic program_load_clear = 1'b0;
	logic program_load_flag, attention_flag, line_transmit_gate, select_active, rx_done;
	logic load_req = 1'b0;
	logic svc_req = 1'b0;
	logic drop = 1'b0;
	logic [3:0] sdev = 4'h1;
	logic [6:0] rx_char;
	logic [1:0] rx_par;
	logic [32:0] rq[$];
	logic [7:0] fq[$];
	logic [32:0] e;
	logic [7:0] f;
	int error_cnt = 0;
	int checked = 0;
	int c;
	int d;
	always #5 clk = ~clk;
	// short line timeout keeps a stuck exchange from stalling the run
	iceps_sequencer #(.TIMEOUT_CYC(2000)) iceps_sequencer_i (.clk, .srst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .line_clk_i(line_clk), .line_clk_o, .line_clk_oe,
		.line_dat_i(line_dat), .line_dat_o, .line_dat_oe, .channel_busy, .attention_flag_clear,
		.program_load_clear, .program_load_flag, .attention_flag, .line_transmit_gate, .select_active);
	iceps_line_unit iceps_line_unit_i (.line_clk_o, .line_clk_oe, .line_dat_o, .line_dat_oe, .load_req,
		.svc_req, .drop_data(drop), .dev(sdev), .line_clk, .line_dat, .rx_done, .rx_char, .rx_par);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic end_of_test();
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [32:0] x);
		rq.push_back(x);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [7:0] svc(input logic [3:0] dv);
		return {1'b0, iceps_pkg::SVC_POLL_CHAR | {3'b000, dv}};
	endfunction : svc
	task automatic pair(input logic [3:0] dv);
		fq.push_back(ESC);
		fq.push_back(LDP);
		fq.push_back(ESC);
		fq.push_back(svc(dv));
	endtask : pair
	task automatic drain();
		for (c = 0; c < 40000 && fq.size() != 0; c++)
			@(posedge clk);
		chk("frames left", 32'h0, 32'(fq.size()));
	endtask : drain
	task automatic gate_wait();
		fq.push_back(ESC);
		for (c = 0; c < 5000 && line_transmit_gate !== 1'b1; c++)
			@(posedge clk);
	endtask : gate_wait
	task automatic pulse(input logic attn);
		@(posedge clk);
		attention_flag_clear <= attn;
		program_load_clear <= !attn;
		@(posedge clk);
		attention_flag_clear <= 1'b0;
		program_load_clear <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : pulse
	always @(posedge rx_done)
	begin
		f = (fq.size() != 0) ? fq.pop_front() : 8'hff;
		chk("frame char", {24'h0, f}, {25'h0, rx_char});
		if (f == LDP)
			chk("poll parity", 32'h3, {30'h0, rx_par});
	end
	always @(posedge clk)
		if (pready === 1'b1)
		begin
			e = rq.pop_front();
			chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
			if (!pwrite)
				chk("prdata", e[31:0], prdata);
		end
	initial
	begin
		void'($urandom(26444));
		sdev = 4'($urandom_range(3, 1));
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		apb(1'b0, iceps_pkg::STAT_OFS, 32'h0, 33'h0_0000_0004);
		apb(1'b0, iceps_pkg::CTRL_OFS, 32'h0, 33'h0_0000_0f11);
		apb(1'b1, iceps_pkg::CTRL_OFS, 32'h0000_0311, 33'h0);
		apb(1'b0, iceps_pkg::CTRL_OFS, 32'h0, 33'h0_0000_0311);
		apb(1'b1, 8'h08, $urandom, 33'h1_0000_0000);
		apb(1'b0, 8'h0c, 32'h0, 33'h1_0000_0000);
		apb(1'b1, iceps_pkg::STAT_OFS, 32'h0, 33'h1_0000_0000);
		for (d = 0; d < 4; d++)
			pair(4'(d % 3 + 1));
		drain();
		chk("flags", 32'h0, {30'h0, program_load_flag, attention_flag});
		svc_req <= 1'b1;
		d = 1;
		do
		begin
			d = d % 3 + 1;
			pair(4'(d));
		end
		while (d != 32'(sdev));
		pair(sdev);
		drain();
		svc_req <= 1'b0;
		gate_wait();
		chk("attention flag", 32'h1, {31'h0, attention_flag});
		pulse(1'b1);
		chk("attention flag", 32'h0, {31'h0, attention_flag});
		load_req <= 1'b1;
		fq.push_back(LDP);
		fq.push_back(ESC);
		fq.push_back(svc(sdev));
		drain();
		load_req <= 1'b0;
		chk("load flag", 32'h1, {31'h0, program_load_flag});
		pulse(1'b0);
		chk("load flag", 32'h0, {31'h0, program_load_flag});
		svc_req <= 1'b1;
		drop <= 1'b1;
		pair(sdev);
		drain();
		svc_req <= 1'b0;
		drop <= 1'b0;
		gate_wait();
		chk("attention flag", 32'h0, {31'h0, attention_flag});
		channel_busy <= 1'b1;
		repeat (5000) @(posedge clk);
		chk("held gate", 32'h0, {31'h0, line_transmit_gate});
		channel_busy <= 1'b0;
		fq.push_back(ESC);
		fq.push_back(svc(4'(sdev % 3 + 1)));
		drain();
		end_of_test();
	end
	initial
	begin
		#1000000;
		error_cnt++;
		end_of_test();
	end
endmodule : tb
